//--- bus_transceiver_mode_control.sv
// Our own choices: the register addresses and the APB register port.
module bus_transceiver_mode_control
	import xcvr_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Controller pins
	input wire logic standby_select_n,
	input wire logic transmit_enable_low,
	input wire logic guardian_enable,
	input wire logic transmit_data,
	input wire logic serial_clk,
	input wire logic serial_select_low,
	output logic receive_data,
	output logic diag_wake_indication_o,
	output logic diag_wake_indication_oe,
	output logic serial_data_out_o,
	output logic serial_data_out_oe,
	// Analog front-end status
	input wire logic vio_uv,
	input wire logic vcc_uv,
	input wire logic vcc_por_ok,
	input wire logic normal_rx_bit,
	input wire logic wake_pattern_seen,
	input wire logic wake_frame_seen,
	input wire logic bus_error_seen,
	// Bus driver control
	output logic bus_line_plus_o,
	output logic bus_line_plus_oe,
	output logic bus_line_minus_o,
	output logic bus_line_minus_oe
);
	logic [PIN_W-1:0] raw, pins, safe; // Pins before and after filtering
	mode_type mode_q, mode_d; // Power mode
	logic wake_q, wake_d; // Wake flag
	logic err_q, err_d; // Error flag
	logic wake_hold_q, wake_hold_d; // Wake indication frozen on main undervoltage
	logic tx_on_q, tx_on_d; // Transmitter active
	logic [31:0] ctrl_q, ctrl_d; // Control register
	logic [EV_W-1:0] ev_q, ev_d; // Sticky events
	logic [EV_W-1:0] mask_q, mask_d; // Interrupt mask
	logic [EV_W-1:0] ev_set; // Event pulses
	logic vio_uv_last_q, vcc_uv_last_q; // Previous undervoltage levels
	logic [SER_W-1:0] shift_q, shift_d; // Serial frame
	logic sclk_last_q, scs_last_q; // Previous serial levels
	logic [31:0] status; // Live status word
	logic [31:0] rdata_d; // Read mux
	logic access, wr, rd, mapped; // Bus decode
	logic wake_ev; // Remote wake seen
	logic tx_ok; // Transmit gating
	logic rxd_d, diag_d, diag_oe_d, sdo_d, sdo_oe_d, irq_d; // Output next values
	logic pready_d, pslverr_d;

	// Offset decode used for reads and writes
	function automatic logic is_mapped(input logic [7:0] a);
		return a == CTRL_OFS || a == STAT_OFS || a == IRQ_STAT_OFS || a == IRQ_MASK_OFS;
	endfunction

	assign raw = {bus_error_seen, wake_frame_seen, wake_pattern_seen, normal_rx_bit, vcc_por_ok,
		vcc_uv, vio_uv, serial_select_low, serial_clk, transmit_data, guardian_enable,
		transmit_enable_low, standby_select_n};

	// Every asynchronous input is filtered here
	pin_sync #(.W(PIN_W), .RST(PIN_RST)) u_sync (
		.clk(mclk),
		.rst(rst),
		.pin(raw),
		.level(pins)
	);

	// Safe internal levels under I/O undervoltage
	always_comb begin
		safe = pins;
		if (pins[PIN_VIO_UV]) begin
			safe[PIN_STB] = 1'b0;
			safe[PIN_GUARD] = 1'b0;
			safe[PIN_TXD] = 1'b0;
			safe[PIN_TRANSMIT_ENABLE_LOW_L] = 1'b1;
			safe[PIN_SCLK] = 1'b1;
			safe[PIN_SCS_L] = 1'b1;
		end
	end

	// Either wake source counts
	assign wake_ev = safe[PIN_WAKE_PAT] | safe[PIN_WAKE_FRM];

	// Mode selection
	always_comb begin
		case (mode_q)
			MODE_OFF: mode_d = safe[PIN_POR_OK] ? MODE_STBY : MODE_OFF;
			MODE_STBY, MODE_NORM: begin
				if (!safe[PIN_POR_OK])
					mode_d = MODE_OFF;
				else if (safe[PIN_STB] && !safe[PIN_VCC_UV])
					mode_d = MODE_NORM;
				else
					mode_d = MODE_STBY;
			end
			default: mode_d = MODE_OFF;
		endcase
	end

	// Transmitter gating
	assign tx_ok = (mode_q == MODE_NORM) && safe[PIN_GUARD] && !safe[PIN_TRANSMIT_ENABLE_LOW_L];

	// Flag next values
	always_comb begin
		wake_d = wake_q;
		err_d = err_q;
		wake_hold_d = wake_hold_q;
		// Transmitter starts at the first low data bit and stops as soon as gated off
		tx_on_d = tx_ok && (tx_on_q || !safe[PIN_TXD]);
		if (mode_q == MODE_OFF) begin
			wake_d = 1'b0;
			err_d = 1'b0;
			wake_hold_d = 1'b0;
		end else begin
			// Back to normal clears the wake flag
			if (mode_q == MODE_STBY && mode_d == MODE_NORM)
				wake_d = 1'b0;
			// Software clears the error flag by writing a one
			if (wr && paddr == STAT_OFS && pwdata[ST_ERR_BIT])
				err_d = 1'b0;
			// Set wins over clear
			if (mode_q == MODE_NORM && mode_d == MODE_STBY && wake_ev)
				wake_d = 1'b1;
			if (mode_q == MODE_STBY && !safe[PIN_VCC_UV] && wake_ev)
				wake_d = 1'b1;
			if (mode_q == MODE_NORM && safe[PIN_ERR_EV])
				err_d = 1'b1;
			// Indication tracks the flag only while the main supply is good
			if (!safe[PIN_VCC_UV])
				wake_hold_d = wake_d;
		end
	end

	// Mode and flag registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_q <= MODE_STBY;
			wake_q <= 1'b0;
			err_q <= 1'b0;
			wake_hold_q <= 1'b0;
			tx_on_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			wake_q <= wake_d;
			err_q <= err_d;
			wake_hold_q <= wake_hold_d;
			tx_on_q <= tx_on_d;
		end
	end

	// Pin indication next values, in priority order
	always_comb begin
		rxd_d = 1'b1;
		diag_d = 1'b1;
		diag_oe_d = 1'b1;
		if (mode_d == MODE_OFF) begin
			diag_oe_d = 1'b0;
			rxd_d = 1'b1;
		end else if (safe[PIN_VIO_UV]) begin
			diag_d = 1'b0;
			rxd_d = 1'b0;
		end else if (mode_q == MODE_NORM) begin
			rxd_d = safe[PIN_RX];
			diag_d = !err_q;
		end else if (safe[PIN_VCC_UV]) begin
			rxd_d = !wake_hold_q;
			diag_d = safe[PIN_STB] ? !err_q : !wake_hold_q;
		end else begin
			rxd_d = !wake_q;
			diag_d = !wake_q;
		end
	end

	// Serial status frame: loaded at select, shifted on falling clock
	always_comb begin
		shift_d = shift_q;
		if (scs_last_q && !safe[PIN_SCS_L])
			shift_d = status[SER_W-1:0];
		else if (!safe[PIN_SCS_L] && sclk_last_q && !safe[PIN_SCLK])
			shift_d = {shift_q[SER_W-2:0], 1'b0};
		sdo_d = shift_d[SER_W-1];
		// Serial output drives only in serial diagnosis mode while selected and not powered off
		sdo_oe_d = ctrl_q[CTRL_SPI_MODE_BIT] && !safe[PIN_SCS_L] && mode_d != MODE_OFF;
	end

	// Serial registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
			sclk_last_q <= 1'b1;
			scs_last_q <= 1'b1;
		end else begin
			shift_q <= shift_d;
			sclk_last_q <= safe[PIN_SCLK];
			scs_last_q <= safe[PIN_SCS_L];
		end
	end

	// Live status word
	always_comb begin
		status = '0;
		status[ST_NORM_BIT] = mode_q == MODE_NORM;
		status[ST_STBY_BIT] = mode_q == MODE_STBY;
		status[ST_OFF_BIT] = mode_q == MODE_OFF;
		status[ST_WAKE_BIT] = wake_q;
		status[ST_ERR_BIT] = err_q;
		status[ST_VIO_UV_BIT] = safe[PIN_VIO_UV];
		status[ST_VCC_UV_BIT] = safe[PIN_VCC_UV];
		status[ST_TX_ON_BIT] = tx_on_q;
	end

	// APB decode; one wait state, answer registered
	assign access = psel && penable && !pready;
	assign mapped = is_mapped(paddr);
	assign wr = access && pwrite && mapped;
	assign rd = access && !pwrite;

	// Event pulses
	always_comb begin
		ev_set = '0;
		ev_set[EV_WAKE_BIT] = wake_d && !wake_q;
		ev_set[EV_ERR_BIT] = err_d && !err_q;
		ev_set[EV_VIO_UV_BIT] = safe[PIN_VIO_UV] && !vio_uv_last_q;
		ev_set[EV_VCC_UV_BIT] = safe[PIN_VCC_UV] && !vcc_uv_last_q;
		ev_set[EV_MODE_BIT] = mode_d != mode_q;
	end

	// Register file next values
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		ev_d = ev_q;
		if (wr && paddr == CTRL_OFS)
			ctrl_d = {31'h0000_0000, pwdata[CTRL_SPI_MODE_BIT]};
		if (wr && paddr == IRQ_MASK_OFS)
			mask_d = pwdata[EV_W-1:0];
		if (wr && paddr == IRQ_STAT_OFS)
			ev_d = ev_q & ~pwdata[EV_W-1:0];
		ev_d = ev_d | ev_set; // Set wins over clear
		case (paddr)
			CTRL_OFS: rdata_d = ctrl_q;
			STAT_OFS: rdata_d = status;
			IRQ_STAT_OFS: rdata_d = {27'h000_0000, ev_q};
			IRQ_MASK_OFS: rdata_d = {27'h000_0000, mask_q};
			default: rdata_d = 32'h0000_0000;
		endcase
		pready_d = access;
		pslverr_d = access && !mapped;
		irq_d = |(ev_d & mask_d);
	end

	// Register file and output registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			mask_q <= IRQ_MASK_RST;
			ev_q <= '0;
			vio_uv_last_q <= 1'b0;
			vcc_uv_last_q <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
			receive_data <= 1'b1;
			diag_wake_indication_o <= 1'b1;
			diag_wake_indication_oe <= 1'b0;
			serial_data_out_o <= 1'b0;
			serial_data_out_oe <= 1'b0;
			bus_line_plus_o <= 1'b0;
			bus_line_plus_oe <= 1'b0;
			bus_line_minus_o <= 1'b0;
			bus_line_minus_oe <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			ev_q <= ev_d;
			vio_uv_last_q <= safe[PIN_VIO_UV];
			vcc_uv_last_q <= safe[PIN_VCC_UV];
			prdata <= rd ? rdata_d : 32'h0000_0000;
			pready <= pready_d;
			pslverr <= pslverr_d;
			irq <= irq_d;
			receive_data <= rxd_d;
			diag_wake_indication_o <= diag_d;
			diag_wake_indication_oe <= diag_oe_d;
			serial_data_out_o <= sdo_d;
			serial_data_out_oe <= sdo_oe_d;
			// Differential drive follows transmit data while active
			bus_line_plus_o <= safe[PIN_TXD];
			bus_line_plus_oe <= tx_on_d;
			bus_line_minus_o <= !safe[PIN_TXD];
			bus_line_minus_oe <= tx_on_d;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_gate_off;
		!tx_ok;
	endsequence
	sequence s_drive_off;
		!bus_line_plus_oe && !bus_line_minus_oe;
	endsequence

	property p_one_mode;
		$onehot(mode_q);
	endproperty
	a_one_mode: assert property (p_one_mode) else $error("Mode not one-hot");

	property p_normal_select;
		(mode_q == MODE_STBY && safe[PIN_STB] && !safe[PIN_VCC_UV] && safe[PIN_POR_OK]) |=> mode_q == MODE_NORM;
	endproperty
	a_normal_select: assert property (p_normal_select) else $error("Normal not entered");

	property p_transmit_enable_low_gate;
		safe[PIN_TRANSMIT_ENABLE_LOW_L] |-> s_gate_off ##1 s_drive_off;
	endproperty
	a_transmit_enable_low_gate: assert property (p_transmit_enable_low_gate) else $error("Driver on with enable high");

	property p_guard_gate;
		!safe[PIN_GUARD] |-> s_gate_off ##1 s_drive_off;
	endproperty
	a_guard_gate: assert property (p_guard_gate) else $error("Driver on with guardian low");

	property p_wake_switch;
		(mode_q == MODE_NORM && mode_d == MODE_STBY && wake_ev) |=> wake_q;
	endproperty
	a_wake_switch: assert property (p_wake_switch) else $error("Wake lost on switch");

	property p_wake_stby;
		(mode_q == MODE_STBY && mode_d == MODE_STBY && !safe[PIN_VCC_UV] && wake_ev) |=> wake_q;
	endproperty
	a_wake_stby: assert property (p_wake_stby) else $error("Standby wake lost");

	property p_hold;
		(mode_q != MODE_OFF && safe[PIN_VCC_UV]) |=> $stable(wake_hold_q);
	endproperty
	a_hold: assert property (p_hold) else $error("Held wake changed");

	property p_safe_levels;
		pins[PIN_VIO_UV] |-> !safe[PIN_STB] && !safe[PIN_GUARD] && safe[PIN_TRANSMIT_ENABLE_LOW_L] && safe[PIN_SCS_L];
	endproperty
	a_safe_levels: assert property (p_safe_levels) else $error("Inputs not forced");

	property p_rx_route;
		(mode_q == MODE_NORM && mode_d == MODE_NORM && !safe[PIN_VIO_UV]) |=> receive_data == $past(safe[PIN_RX]);
	endproperty
	a_rx_route: assert property (p_rx_route) else $error("Receive not routed");

	property p_off_pins;
		(mode_d == MODE_OFF) |=> !diag_wake_indication_oe && receive_data && !serial_data_out_oe;
	endproperty
	a_off_pins: assert property (p_off_pins) else $error("Power-off pins wrong");

	property p_vio_pins;
		(mode_d != MODE_OFF && safe[PIN_VIO_UV]) |=> !receive_data && !diag_wake_indication_o && !serial_data_out_oe;
	endproperty
	a_vio_pins: assert property (p_vio_pins) else $error("Undervoltage pins wrong");
endmodule

//--- xcvr_pkg.sv
package xcvr_pkg;
	// Core clock rate
	localparam int unsigned CLK_HZ = 40_000_000;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
	// Control fields
	localparam int CTRL_SPI_MODE_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Status fields
	localparam int ST_NORM_BIT = 0;
	localparam int ST_STBY_BIT = 1;
	localparam int ST_OFF_BIT = 2;
	localparam int ST_WAKE_BIT = 3;
	localparam int ST_ERR_BIT = 4;
	localparam int ST_VIO_UV_BIT = 5;
	localparam int ST_VCC_UV_BIT = 6;
	localparam int ST_TX_ON_BIT = 7;
	// Interrupt event fields
	localparam int EV_WAKE_BIT = 0;
	localparam int EV_ERR_BIT = 1;
	localparam int EV_VIO_UV_BIT = 2;
	localparam int EV_VCC_UV_BIT = 3;
	localparam int EV_MODE_BIT = 4;
	localparam int EV_W = 5;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;
	// Serial status frame length
	localparam int SER_W = 8;
	// Synchronised pin vector positions
	localparam int PIN_STB = 0;
	localparam int PIN_TRANSMIT_ENABLE_LOW_L = 1;
	localparam int PIN_GUARD = 2;
	localparam int PIN_TXD = 3;
	localparam int PIN_SCLK = 4;
	localparam int PIN_SCS_L = 5;
	localparam int PIN_VIO_UV = 6;
	localparam int PIN_VCC_UV = 7;
	localparam int PIN_POR_OK = 8;
	localparam int PIN_RX = 9;
	localparam int PIN_WAKE_PAT = 10;
	localparam int PIN_WAKE_FRM = 11;
	localparam int PIN_ERR_EV = 12;
	localparam int PIN_W = 13;
	// Pin reset levels: the pad pulls, and main supply good because reset is the power-on detect
	localparam logic [PIN_W-1:0] PIN_RST = 13'h0332;
	// Power modes, one-hot
	typedef enum logic [2:0] {
		MODE_OFF = 3'b001,
		MODE_STBY = 3'b010,
		MODE_NORM = 3'b100
	} mode_type;
endpackage

//--- pin_sync.sv
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Raw pins and filtered result
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_q, s2_q, s3_q;
	logic [W-1:0] level_d;

	// A bit moves only once stages two and three agree
	always_comb begin
		level_d = (s2_q & s3_q) | (level & (s2_q ^ s3_q));
	end

	// Register chain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			level <= RST;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level <= level_d;
		end
	end
endmodule

//--- ctrl_model.sv
// Protocol controller and host pins facing the transceiver block
module ctrl_model (
	// Clock
	input wire logic mclk,
	// Controller pins toward the block
	output logic standby_select_n,
	output logic transmit_enable_low,
	output logic guardian_enable,
	output logic transmit_data,
	output logic serial_clk,
	output logic serial_select_low,
	// Serial status line from the block
	input wire logic serial_data_out_o,
	input wire logic serial_data_out_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins start at their pulled idle levels
	initial begin
		standby_select_n = 1'b0;
		transmit_enable_low = 1'b1;
		guardian_enable = 1'b0;
		transmit_data = 1'b0;
		serial_clk = 1'b1;
		serial_select_low = 1'b1;
	end

	// Applies a set of control levels just after a rising edge
	task automatic set_pins(input logic stb, input logic transmit_enable_low_l, input logic guard, input logic txd);
		@(posedge mclk);
		standby_select_n <= stb;
		transmit_enable_low <= transmit_enable_low_l;
		guardian_enable <= guard;
		transmit_data <= txd;
	endtask

	// Reads one status frame MSB first; the serial clock stands still outside frames
	task automatic serial_read(output logic [7:0] val);
		val = 8'h00;
		@(posedge mclk);
		serial_select_low <= 1'b0;
		repeat (10) @(posedge mclk);
		for (int i = 7; i >= 0; i--) begin
			// An undriven line reads as unknown so it can never match
			val[i] = serial_data_out_oe ? serial_data_out_o : 1'bx;
			serial_clk <= 1'b0;
			repeat (8) @(posedge mclk);
			serial_clk <= 1'b1;
			repeat (8) @(posedge mclk);
		end
		serial_select_low <= 1'b1;
	endtask
endmodule

//--- testbench.sv
// Self-checking bench for the transceiver mode and indication logic
module testbench import xcvr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// Expected status words
	localparam logic [31:0] S_NRM = 32'h1 << ST_NORM_BIT;
	localparam logic [31:0] S_STB = 32'h1 << ST_STBY_BIT;
	localparam int SETTLE = 8;
	// Clock, reset and bench inputs
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic vio_uv = 1'b0;
	logic vcc_uv = 1'b0;
	logic vcc_por_ok = 1'b1;
	logic rx_bit = 1'b1;
	logic wpat = 1'b0;
	logic wfrm = 1'b0;
	logic berr = 1'b0;
	// Design outputs and controller pins
	logic [31:0] prdata;
	logic pready, pslverr, irq, rxd, dg_o, dg_oe, sdo_o, sdo_oe, bp_o, bp_oe, bm_o, bm_oe;
	logic stb, transmit_enable_low_l, guard, txd, sclk, scs_l;
	// Bookkeeping
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic er;

	always #12.5 mclk = ~mclk;

	bus_transceiver_mode_control uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.standby_select_n(stb), .transmit_enable_low(transmit_enable_low_l), .guardian_enable(guard), .transmit_data(txd),
		.serial_clk(sclk), .serial_select_low(scs_l), .receive_data(rxd), .diag_wake_indication_o(dg_o),
		.diag_wake_indication_oe(dg_oe), .serial_data_out_o(sdo_o), .serial_data_out_oe(sdo_oe),
		.vio_uv(vio_uv), .vcc_uv(vcc_uv), .vcc_por_ok(vcc_por_ok), .normal_rx_bit(rx_bit),
		.wake_pattern_seen(wpat), .wake_frame_seen(wfrm), .bus_error_seen(berr), .bus_line_plus_o(bp_o),
		.bus_line_plus_oe(bp_oe), .bus_line_minus_o(bm_o), .bus_line_minus_oe(bm_oe));

	ctrl_model far (.mclk(mclk), .standby_select_n(stb), .transmit_enable_low(transmit_enable_low_l), .guardian_enable(guard),
		.transmit_data(txd), .serial_clk(sclk), .serial_select_low(scs_l), .serial_data_out_o(sdo_o),
		.serial_data_out_oe(sdo_oe));

	// Prints the counts and the verdict, then stops
	task automatic finish_test();
		$display("Checks: %0d, errors: %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			finish_test();
		end
	end

	// Compares one value and reports a mismatch
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled high or 50 wait cycles pass
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge mclk);
		end
		chk("apb wait", 32'h0, (n >= 50) ? 32'h1 : 32'h0);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads a register and compares it
	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask

	// Lets pin changes pass the synchroniser and the output registers
	task automatic settle();
		repeat (SETTLE) @(posedge mclk);
	endtask

	// Holds an event input for four cycles
	task automatic pulse(input int which);
		@(posedge mclk);
		if (which == 0) wpat <= 1'b1; else if (which == 1) wfrm <= 1'b1; else berr <= 1'b1;
		repeat (4) @(posedge mclk);
		wpat <= 1'b0;
		wfrm <= 1'b0;
		berr <= 1'b0;
		settle();
	endtask

	// Reset state, register defaults and simple diagnosis mode
	task automatic t_reset();
		rchk("status", STAT_OFS, S_STB);
		chk("rxd idle", 32'h1, rxd);
		chk("diag", 32'h3, {dg_oe, dg_o});
		chk("sdo oe", 32'h0, sdo_oe);
		rchk("ctrl", CTRL_OFS, CTRL_RST);
		rchk("mask", IRQ_MASK_OFS, 32'(IRQ_MASK_RST));
		apb(1'b1, IRQ_STAT_OFS, 32'h1f);
		rchk("irq stat", IRQ_STAT_OFS, 32'h0);
		apb(1'b1, 8'h10, 32'h1);
		chk("unmapped err", 32'h1, er);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped rd", 32'h0, rd);
		chk("unmapped rd err", 32'h1, er);
	endtask

	// Normal mode selection and receiver routing
	task automatic t_normal();
		far.set_pins(1'b1, 1'b1, 1'b0, 1'b1);
		settle();
		rchk("status", STAT_OFS, S_NRM);
		rchk("mode ev", IRQ_STAT_OFS, 32'h1 << EV_MODE_BIT);
		apb(1'b1, IRQ_STAT_OFS, 32'h1f);
		for (int b = 0; b < 2; b++) begin
			@(posedge mclk);
			rx_bit <= b[0];
			settle();
			chk("rxd", 32'(b), rxd);
		end
	endtask

	// Transmitter gating by enable and guardian
	task automatic t_tx();
		for (int i = 0; i < 4; i++) begin
			far.set_pins(1'b1, i[0], i[1], 1'b0);
			settle();
			chk("bus oe", {30'h0, {2{i == 2}}}, {bp_oe, bm_oe});
		end
		far.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
		settle();
		chk("bus drive", 32'h2, {bp_o, bm_o});
		far.set_pins(1'b1, 1'b1, 1'b0, 1'b1);
	endtask

	// Error flag, interrupt raise, mask and clear
	task automatic t_error();
		apb(1'b1, IRQ_MASK_OFS, 32'h1 << EV_ERR_BIT);
		pulse(2);
		chk("diag err", 32'h2, {dg_oe, dg_o});
		chk("irq on", 32'h1, irq);
		// Clear event and flag, so the next error raises a fresh event
		apb(1'b1, IRQ_STAT_OFS, 32'h1 << EV_ERR_BIT);
		apb(1'b1, STAT_OFS, 32'h1 << ST_ERR_BIT);
		settle();
		chk("irq off", 32'h0, irq);
		chk("diag cleared", 32'h3, {dg_oe, dg_o});
		apb(1'b1, IRQ_MASK_OFS, 32'h0);
		pulse(2);
		chk("irq masked", 32'h0, irq);
		rchk("err ev", IRQ_STAT_OFS, 32'h1 << EV_ERR_BIT);
		apb(1'b1, IRQ_STAT_OFS, 32'h1f);
		apb(1'b1, STAT_OFS, 32'h1 << ST_ERR_BIT);
		settle();
		chk("diag clear", 32'h3, {dg_oe, dg_o});
	endtask

	// Wake by pattern, by frame, and with main undervoltage
	task automatic t_wake();
		for (int s = 0; s < 3; s++) begin
			far.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
			@(posedge mclk);
			vcc_uv <= (s == 2);
			settle();
			pulse(s == 1 ? 1 : 0);
			chk("rxd wake", (s == 2) ? 32'h1 : 32'h0, rxd);
			chk("diag wake", (s == 2) ? 32'h1 : 32'h0, dg_o);
			if (s == 0) begin
				@(posedge mclk);
				vcc_uv <= 1'b1;
				settle();
				chk("rxd held", 32'h0, {dg_o, rxd});
			end
			@(posedge mclk);
			vcc_uv <= 1'b0;
			far.set_pins(1'b1, 1'b1, 1'b0, 1'b1);
			settle();
		end
		// Wake event held across the switch toward standby
		@(posedge mclk);
		wfrm <= 1'b1;
		far.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
		settle();
		wfrm <= 1'b0;
		chk("wake switch", 32'h0, {dg_o, rxd});
		far.set_pins(1'b1, 1'b1, 1'b0, 1'b1);
		settle();
	endtask

	// I/O undervoltage forcing while transmitting
	task automatic t_vio();
		far.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
		settle();
		chk("tx on", 32'h3, {bp_oe, bm_oe});
		apb(1'b1, IRQ_STAT_OFS, 32'h1f);
		@(posedge mclk);
		vio_uv <= 1'b1;
		settle();
		chk("vio outs", 32'h4, {dg_oe, dg_o, rxd});
		chk("vio sdo", 32'h0, sdo_oe);
		chk("vio bus", 32'h0, {bp_oe, bm_oe});
		rchk("vio stat", STAT_OFS, S_STB | (32'h1 << ST_VIO_UV_BIT));
		rchk("vio ev", IRQ_STAT_OFS, (32'h1 << EV_VIO_UV_BIT) | (32'h1 << EV_MODE_BIT));
		@(posedge mclk);
		vio_uv <= 1'b0;
		far.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
		settle();
	endtask

	// Power-off and recovery into standby
	task automatic t_off();
		@(posedge mclk);
		vcc_por_ok <= 1'b0;
		settle();
		chk("off pins", 32'h4, {dg_oe, rxd, bp_oe, bm_oe});
		rchk("off stat", STAT_OFS, 32'h1 << ST_OFF_BIT);
		pulse(0);
		@(posedge mclk);
		vcc_por_ok <= 1'b1;
		settle();
		rchk("recover", STAT_OFS, S_STB);
		chk("rxd", 32'h1, rxd);
	endtask

	// Status readout over the serial port
	task automatic t_serial();
		logic [7:0] v;
		apb(1'b1, CTRL_OFS, 32'h1 << CTRL_SPI_MODE_BIT);
		rchk("ctrl", CTRL_OFS, 32'h1 << CTRL_SPI_MODE_BIT);
		far.serial_read(v);
		chk("serial", S_STB, 32'(v));
		apb(1'b1, CTRL_OFS, 32'h0);
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		repeat (20) @(posedge mclk);
		t_reset();
		t_normal();
		t_tx();
		t_error();
		t_wake();
		t_vio();
		t_off();
		t_serial();
		finish_test();
	end
endmodule
